// [qscp_side_port_regs.vh]
// Register offsets, field positions and reset values of the side port
`ifndef QSCP_SIDE_PORT_REGS_VH
`define QSCP_SIDE_PORT_REGS_VH

// Register offsets (management register numbers)
`define QSCP_CTRL_OFFSET       5'h00
`define QSCP_ADV_OFFSET        5'h04

// Control register fields
`define QSCP_CTRL_SOFT_RESET   15
`define QSCP_CTRL_AN_ENABLE    12
`define QSCP_CTRL_POWER_DOWN   11
`define QSCP_CTRL_ISOLATE      10
`define QSCP_CTRL_AN_RESTART   9
`define QSCP_CTRL_UNIDIR       5
`define QSCP_CTRL_RESET        16'h0000
`define QSCP_CTRL_WR_MASK      16'h1e20

// Configuration vector fields
`define QSCP_CFG_UNIDIR        0
`define QSCP_CFG_POWER_DOWN    2
`define QSCP_CFG_ISOLATE       3
`define QSCP_CFG_AN_ENABLE     4

// Advertisement register values
`define QSCP_ADV_MAC_VALUE     16'h0001
`define QSCP_ADV_PHY_MASK      16'hdc01
`define QSCP_ADV_ALWAYS_ONE    16'h0001
`define QSCP_ADV_RESET         16'h0001

// Status vector fields
`define QSCP_STAT_IDLE         3
`define QSCP_STAT_INVALID      4
`define QSCP_STAT_DISP_ERR     5
`define QSCP_STAT_BAD_CODE     6

`endif

// [qscp_rise_detect.v]
// Rising edge detector for a group of strobes
`timescale 1ns/1ps
`default_nettype none

module qscp_rise_detect #(
  parameter WIDTH = 3
) (
  // Clock and reset
  input  wire             clk,
  input  wire             reset_n,
  // Strobes and edge pulses
  input  wire [WIDTH-1:0] strobe_in,
  output wire [WIDTH-1:0] rise_pulse
);

  reg [WIDTH-1:0] strobe_prev_r;

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      strobe_prev_r <= {WIDTH{1'b0}};
    else
      strobe_prev_r <= strobe_in;
  end

  // One pulse per low-to-high transition
  assign rise_pulse = strobe_in & ~strobe_prev_r;

endmodule

`default_nettype wire

// [qscp_side_port.v]
// Per-channel sideband configuration and status port
// What this block does
// - Bit 0 forces transmit regardless of receiver
// - Bit 2 powers down transceiver until reset
// - Power-down honoured on channel zero only
// - Bit 3 isolates the GMII client interface
// - Bit 4 enables auto-negotiation if present
// - Valid rising edge loads Control register
// - MAC mode: advertisement fixed at 0x0001
// - Advertisement speed, duplex, ack, link fields
// - Advert strobe rising edge loads advertisement
// - Restart strobe edge sets Control bit 9
// - Status flag while receiving idle sets
// - Status bit 4 on invalid during idle/config
// - Status bit 5 on running disparity error
// - Status bit 6 on code not in table
// - Everything but the asynchronous reset_n synchronous to core reference clock
`timescale 1ns/1ps
`default_nettype none
`include "qscp_side_port_regs.vh"

module qscp_side_port #(
  parameter CHANNEL      = 0,
  parameter MAC_MODE     = 0,
  parameter MDIO_PRESENT = 1,
  parameter AN_PRESENT   = 1
) (
  // Core reference clock and reset
  input  wire        clk,
  input  wire        reset_n,
  // Configuration vectors and strobes
  input  wire [5:0]  config_vector,
  input  wire        config_load_strobe,
  input  wire [15:0] advert_setting_bus,
  input  wire        advert_setting_load_strobe,
  input  wire        negotiation_restart_strobe,
  // Management register access
  input  wire        mgmt_req,
  input  wire        mgmt_we,
  input  wire [4:0]  mgmt_addr,
  input  wire [15:0] mgmt_wdata,
  output reg  [15:0] mgmt_rdata_r,
  output reg         mgmt_ack_r,
  // Receive decoder events
  input  wire [2:0]  rx_link_status_in,
  input  wire        rx_idle_in,
  input  wire        rx_invalid_in,
  input  wire        rx_disp_err_in,
  input  wire        rx_bad_code_in,
  // Status vector
  output reg  [6:0]  status_vector_r,
  // Controls to the core
  output reg  [15:0] control_reg_r,
  output reg  [15:0] negotiation_advertisement_r,
  output reg         tx_unidir_r,
  output reg         serdes_power_down_r,
  output reg         gmii_isolate_r,
  output reg         an_enable_r,
  output reg         an_restart_r
);

  // *********************************************************
  // Strobe edge detection
  // *********************************************************
  wire [2:0] rise;
  wire       cfg_rise;
  wire       adv_rise;
  wire       rst_rise;

  qscp_rise_detect #(
    .WIDTH (3)
  ) u_rise (
    .clk        (clk),
    .reset_n    (reset_n),
    .strobe_in  ({negotiation_restart_strobe,
                  advert_setting_load_strobe,
                  config_load_strobe}),
    .rise_pulse (rise)
  );

  assign cfg_rise = rise[0];
  assign adv_rise = rise[1];
  assign rst_rise = rise[2];

  // *********************************************************
  // Helper functions
  // *********************************************************
  // Map the configuration vector onto Control register bits
  function [15:0] cfg_to_ctrl;
    input [5:0] cfg;
    reg   [15:0] c;
    begin
      c = 16'h0000;
      c[`QSCP_CTRL_UNIDIR]     = cfg[`QSCP_CFG_UNIDIR];
      if (CHANNEL == 0)
        c[`QSCP_CTRL_POWER_DOWN] = cfg[`QSCP_CFG_POWER_DOWN];
      c[`QSCP_CTRL_ISOLATE]    = cfg[`QSCP_CFG_ISOLATE];
      if (AN_PRESENT != 0)
        c[`QSCP_CTRL_AN_ENABLE] = cfg[`QSCP_CFG_AN_ENABLE];
      cfg_to_ctrl = c;
    end
  endfunction

  // Shape an advertisement word for the current mode
  function [15:0] adv_shape;
    input [15:0] val;
    begin
      if (MAC_MODE != 0)
        adv_shape = `QSCP_ADV_MAC_VALUE;
      else
        adv_shape = (val & `QSCP_ADV_PHY_MASK)
                    | `QSCP_ADV_ALWAYS_ONE;
    end
  endfunction

  // *********************************************************
  // Management decode
  // *********************************************************
  wire mgmt_wr;
  wire wr_ctrl;
  wire wr_adv;
  wire soft_reset;

  assign mgmt_wr    = mgmt_req & mgmt_we & (MDIO_PRESENT != 0);
  assign wr_ctrl    = mgmt_wr & (mgmt_addr == `QSCP_CTRL_OFFSET);
  assign wr_adv     = mgmt_wr & (mgmt_addr == `QSCP_ADV_OFFSET);
  assign soft_reset = wr_ctrl & mgmt_wdata[`QSCP_CTRL_SOFT_RESET];

  // *********************************************************
  // Control register
  // *********************************************************
  reg [15:0] ctrl_nxt;
  reg [15:0] ctrl_load;

  always @*
  begin
    ctrl_load = cfg_to_ctrl(config_vector);
    ctrl_nxt  = control_reg_r;
    // Restart bit clears itself after one cycle
    ctrl_nxt[`QSCP_CTRL_AN_RESTART] = 1'b0;
    if (MDIO_PRESENT == 0)
    begin
      // No management: the vector drives the register directly
      ctrl_nxt = ctrl_load;
      ctrl_nxt[`QSCP_CTRL_POWER_DOWN] =
        ctrl_load[`QSCP_CTRL_POWER_DOWN] |
        control_reg_r[`QSCP_CTRL_POWER_DOWN];
    end
    else if (soft_reset)
      ctrl_nxt = `QSCP_CTRL_RESET;
    else if (cfg_rise)
    begin
      // Strobe wins over a management write in the same cycle, unless the write sets soft reset
      ctrl_nxt = ctrl_load;
      ctrl_nxt[`QSCP_CTRL_POWER_DOWN] =
        ctrl_load[`QSCP_CTRL_POWER_DOWN] |
        control_reg_r[`QSCP_CTRL_POWER_DOWN];
    end
    else if (wr_ctrl)
    begin
      ctrl_nxt = mgmt_wdata & `QSCP_CTRL_WR_MASK;
      if (CHANNEL != 0)
        ctrl_nxt[`QSCP_CTRL_POWER_DOWN] = 1'b0;
      if (AN_PRESENT == 0)
      begin
        ctrl_nxt[`QSCP_CTRL_AN_ENABLE]  = 1'b0;
        ctrl_nxt[`QSCP_CTRL_AN_RESTART] = 1'b0;
      end
      // Power-down only leaves through reset
      ctrl_nxt[`QSCP_CTRL_POWER_DOWN] =
        ctrl_nxt[`QSCP_CTRL_POWER_DOWN] |
        control_reg_r[`QSCP_CTRL_POWER_DOWN];
    end
    if ((AN_PRESENT != 0) && rst_rise && !soft_reset)
      ctrl_nxt[`QSCP_CTRL_AN_RESTART] = 1'b1;
  end

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      control_reg_r <= `QSCP_CTRL_RESET;
    else
      control_reg_r <= ctrl_nxt;
  end

  // *********************************************************
  // Advertisement register
  // *********************************************************
  reg [15:0] adv_nxt;

  always @*
  begin
    adv_nxt = negotiation_advertisement_r;
    if (MAC_MODE != 0)
      adv_nxt = `QSCP_ADV_MAC_VALUE;
    else if (MDIO_PRESENT == 0)
      adv_nxt = adv_shape(advert_setting_bus);
    else if (adv_rise)
      adv_nxt = adv_shape(advert_setting_bus);
    else if (wr_adv)
      adv_nxt = adv_shape(mgmt_wdata);
  end

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      negotiation_advertisement_r <= `QSCP_ADV_RESET;
    else
      negotiation_advertisement_r <= adv_nxt;
  end

  // *********************************************************
  // Control outputs
  // *********************************************************
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_unidir_r         <= 1'b0;
      serdes_power_down_r <= 1'b0;
      gmii_isolate_r      <= 1'b0;
      an_enable_r         <= 1'b0;
      an_restart_r        <= 1'b0;
    end
    else
    begin
      tx_unidir_r         <= ctrl_nxt[`QSCP_CTRL_UNIDIR];
      serdes_power_down_r <= ctrl_nxt[`QSCP_CTRL_POWER_DOWN];
      gmii_isolate_r      <= ctrl_nxt[`QSCP_CTRL_ISOLATE];
      an_enable_r         <= ctrl_nxt[`QSCP_CTRL_AN_ENABLE];
      an_restart_r        <= ctrl_nxt[`QSCP_CTRL_AN_RESTART];
    end
  end

  // *********************************************************
  // Status vector
  // *********************************************************
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      status_vector_r <= 7'h00;
    else
    begin
      status_vector_r[2:0] <= rx_link_status_in;
      status_vector_r[`QSCP_STAT_IDLE]     <= rx_idle_in;
      status_vector_r[`QSCP_STAT_INVALID]  <= rx_invalid_in;
      status_vector_r[`QSCP_STAT_DISP_ERR] <= rx_disp_err_in;
      status_vector_r[`QSCP_STAT_BAD_CODE] <= rx_bad_code_in;
    end
  end

  // *********************************************************
  // Management read and acknowledge
  // *********************************************************
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mgmt_rdata_r <= 16'h0000;
      mgmt_ack_r   <= 1'b0;
    end
    else
    begin
      mgmt_ack_r <= mgmt_req;
      if (mgmt_req && !mgmt_we)
      begin
        case (mgmt_addr)
          `QSCP_CTRL_OFFSET: mgmt_rdata_r <= control_reg_r;
          `QSCP_ADV_OFFSET:  mgmt_rdata_r <= negotiation_advertisement_r;
          default:           mgmt_rdata_r <= 16'h0000;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// [qscp_side_port_sva.sv]
// Concurrent checks on the side port
`timescale 1ns/1ps
`default_nettype none
module qscp_side_port_sva #(
  parameter CHANNEL    = 0,
  parameter MAC_MODE   = 0,
  parameter AN_PRESENT = 1
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // Port inputs
  input wire logic [5:0]  config_vector,
  input wire logic        config_load_strobe,
  input wire logic [15:0] advert_setting_bus,
  input wire logic        advert_setting_load_strobe,
  input wire logic        negotiation_restart_strobe,
  input wire logic        mgmt_req,
  input wire logic        mgmt_we,
  input wire logic        rx_idle_in,
  input wire logic        rx_invalid_in,
  input wire logic        rx_disp_err_in,
  input wire logic        rx_bad_code_in,
  // Port outputs
  input wire logic [6:0]  status_vector_r,
  input wire logic [15:0] control_reg_r,
  input wire logic [15:0] negotiation_advertisement_r
);
  wire mgmt_wr;
  assign mgmt_wr = mgmt_req && mgmt_we;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ***
  // Assertions
  // ***
  chk_cfg_load: assert property (
    $rose(config_load_strobe) && !mgmt_wr |=> {control_reg_r[12],
    control_reg_r[10], control_reg_r[5]} == $past({AN_PRESENT != 0 &&
    config_vector[4], config_vector[3], config_vector[0]}))
    else $error("config load");
  chk_pd_load: assert property (
    $rose(config_load_strobe) && !mgmt_wr |=> control_reg_r[11] ==
    ($past(control_reg_r[11]) | (CHANNEL == 0 && $past(config_vector[2]))))
    else $error("power down load");
  chk_pd_sticky: assert property (
    control_reg_r[11] && !mgmt_wr |=> control_reg_r[11])
    else $error("power down dropped");
  chk_held_cfg: assert property (
    config_load_strobe && $past(config_load_strobe) && $past(reset_n)
    && !mgmt_wr |=> $stable(control_reg_r[12:10]))
    else $error("held strobe reloaded");
  chk_adv_load: assert property (
    $rose(advert_setting_load_strobe) |=> negotiation_advertisement_r ==
    (MAC_MODE ? 16'h0001 : $past(advert_setting_bus) & 16'hdc01 | 16'h0001))
    else $error("advert load");
  chk_adv_fixed: assert property (
    MAC_MODE != 0 |-> negotiation_advertisement_r == 16'h0001)
    else $error("mac advert changed");
  chk_restart_bit: assert property (
    (AN_PRESENT != 0) && $rose(negotiation_restart_strobe) && !mgmt_wr
    |=> control_reg_r[9]
    ##1 !control_reg_r[9]) else $error("restart bit");
  chk_status_flags: assert property (
    1'b1 |=> status_vector_r[6:3] == $past({rx_bad_code_in,
    rx_disp_err_in, rx_invalid_in, rx_idle_in})) else $error("status");
  chk_an_absent: assert property (
    AN_PRESENT == 0 |-> control_reg_r[12] == 1'b0
    && control_reg_r[9] == 1'b0) else $error("negotiation bits set");
endmodule

bind qscp_side_port qscp_side_port_sva #(.CHANNEL(CHANNEL),
  .MAC_MODE(MAC_MODE), .AN_PRESENT(AN_PRESENT)) i_sva (.*);
`default_nettype wire

// [qscp_user_cfg.sv]
// Model of the user logic driving the configuration strobes
`timescale 1ns/1ps
`default_nettype none
module qscp_user_cfg (
  // Clock
  input  wire logic        clk,
  // Vectors and strobes
  output var  logic [5:0]  config_vector,
  output var  logic [15:0] advert_setting_bus,
  output wire logic        config_load_strobe,
  output wire logic        advert_setting_load_strobe,
  output wire logic        negotiation_restart_strobe
);
  logic [2:0] stb;
  assign {negotiation_restart_strobe, advert_setting_load_strobe,
    config_load_strobe} = stb;
  initial
  begin
    stb = 3'h0;
    config_vector = 6'h00;
    advert_setting_bus = 16'h0000;
  end
  // ***
  // Fresh rising edge on strobe k, with a new value for strobe 0 or 1
  // ***
  task send(input int k, input logic [15:0] v);
    @(negedge clk);
    stb[k] = 1'b0;
    @(negedge clk);
    if (k == 0)
      config_vector = v[5:0];
    if (k == 1)
      advert_setting_bus = v;
    stb[k] = 1'b1;
  endtask
endmodule
`default_nettype wire

// [qscp_side_port_test.sv]
// Self-checking bench for the side port
`timescale 1ns/1ps
`default_nettype none
module qscp_side_port_test;
  logic        clk = 1'b0;
  logic        reset_n = 1'b1;
  logic [5:0]  config_vector;
  logic [15:0] advert_setting_bus, mgmt_wdata, mgmt_rdata_r, adv1;
  logic [15:0] control_reg_r, negotiation_advertisement_r;
  logic [6:0]  status_vector_r;
  logic [4:0]  mgmt_addr;
  logic [2:0]  rx_link_status_in;
  logic        config_load_strobe, advert_setting_load_strobe;
  logic        negotiation_restart_strobe, mgmt_req, mgmt_we, mgmt_ack_r;
  logic        rx_idle_in, rx_invalid_in, rx_disp_err_in, rx_bad_code_in;
  logic        tx_unidir_r, serdes_power_down_r, gmii_isolate_r;
  logic        an_enable_r, an_restart_r, pd1, an0, rs0;
  int          fails = 0;
  int          cmp_count = 0;
  // Kind, value and expected register
  logic [32:0] rows [0:10] = '{
    33'h0_0001_0020, 33'h0_0008_0400, 33'h0_0010_1000, 33'h0_0022_0000,
    33'h1_ffff_dc01, 33'h1_0800_0801, 33'h1_1400_1401, 33'h1_0000_0001,
    33'h1_4c00_4c01, 33'h1_8000_8001, 33'h0_0019_1420};

  qscp_side_port i_dut (.*);
  qscp_side_port #(.CHANNEL(1), .MAC_MODE(1)) i_dut_mac (.*,
    .mgmt_rdata_r(), .mgmt_ack_r(), .status_vector_r(),
    .control_reg_r(), .negotiation_advertisement_r(adv1),
    .tx_unidir_r(), .serdes_power_down_r(pd1), .gmii_isolate_r(),
    .an_enable_r(), .an_restart_r());
  qscp_side_port #(.AN_PRESENT(0)) i_dut_noan (.*,
    .mgmt_rdata_r(), .mgmt_ack_r(), .status_vector_r(),
    .control_reg_r(), .negotiation_advertisement_r(),
    .tx_unidir_r(), .serdes_power_down_r(), .gmii_isolate_r(),
    .an_enable_r(an0), .an_restart_r(rs0));
  qscp_user_cfg u_cfg (.*);

  task check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task stop_test;
    $display("fails %0d cmp_count %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task mgmt(input logic w, input logic [4:0] a, input logic [15:0] d);
    @(negedge clk);
    {mgmt_req, mgmt_we, mgmt_addr, mgmt_wdata} = {1'b1, w, a, d};
    @(negedge clk);
    mgmt_req = 1'b0;
    check({15'h0, mgmt_ack_r}, 16'h0001);
  endtask

  initial
    forever #10 clk = ~clk;
  initial
  begin
    #50000;
    fails++;
    stop_test;
  end
  // ***
  // Row loop, then hand-written cases
  // ***
  initial
  begin
    {mgmt_req, mgmt_we, mgmt_addr, mgmt_wdata} = 23'h0;
    {rx_link_status_in, rx_idle_in, rx_invalid_in} = 5'h0;
    {rx_disp_err_in, rx_bad_code_in} = 2'h0;
    #1 reset_n = 1'b0;
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    check(control_reg_r, 16'h0000);
    check(negotiation_advertisement_r, 16'h0001);
    foreach (rows[i])
    begin
      u_cfg.send(int'(rows[i][32]), rows[i][31:16]);
      repeat (2) @(negedge clk);
      if (rows[i][32])
        check(negotiation_advertisement_r, rows[i][15:0]);
      else
        check({control_reg_r[15:13], an_enable_r, control_reg_r[11],
          gmii_isolate_r, control_reg_r[9:6], tx_unidir_r,
          control_reg_r[4:0]}, rows[i][15:0]);
    end
    u_cfg.config_vector = 6'h01;
    u_cfg.advert_setting_bus = 16'h0000;
    repeat (3) @(negedge clk);
    check(control_reg_r, 16'h1420);
    check(negotiation_advertisement_r, 16'h8001);
    check({14'h0, an_enable_r, an0}, 16'h0002);
    mgmt(1'b1, 5'h00, 16'h1000);
    mgmt(1'b0, 5'h00, 16'h0000);
    check(mgmt_rdata_r, 16'h1000);
    u_cfg.send(0, 16'h0008);
    @(negedge clk);
    check(control_reg_r, 16'h0400);
    mgmt(1'b1, 5'h04, 16'hffff);
    check(negotiation_advertisement_r, 16'hdc01);
    u_cfg.send(1, 16'h1800);
    @(negedge clk);
    check(negotiation_advertisement_r, 16'h1801);
    check(adv1, 16'h0001);
    mgmt(1'b0, 5'h04, 16'h0000);
    check(mgmt_rdata_r, 16'h1801);
    repeat (2)
    begin
      u_cfg.send(2, 16'h0000);
      @(negedge clk);
      check({14'h0, control_reg_r[9], an_restart_r}, 16'h0003);
      check({15'h0, rs0}, 16'h0000);
      @(negedge clk);
      check(control_reg_r, 16'h0400);
    end
    u_cfg.send(0, 16'h0004);
    u_cfg.send(0, 16'h0000);
    repeat (2) @(negedge clk);
    check({14'h0, serdes_power_down_r, pd1}, 16'h0002);
    mgmt(1'b1, 5'h00, 16'h8000);
    @(negedge clk);
    check({control_reg_r[15:1], serdes_power_down_r}, 16'h0000);
    for (int i = 0; i < 4; i++)
    begin
      {rx_bad_code_in, rx_disp_err_in, rx_invalid_in, rx_idle_in} = 4'h1 << i;
      rx_link_status_in = 3'h5;
      @(negedge clk);
      check({9'h0, status_vector_r}, {9'h0, 4'h1 << i, 3'h5});
    end
    stop_test;
  end
endmodule
`default_nettype wire
